/* File: hw/autoneg_regs_pkg.sv */
// Constants for the autonegotiation transmit-level and partner page registers.
// Assumes a 16-bit management data path inside the autonegotiation device.
package autoneg_regs_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned PAGE_W = 48;
  localparam int unsigned MIN_ADDR_W = 10;

  // Register addresses
  localparam logic [15:0] LOCAL_ADVERT_UPPER_OFS = 16'h0204;
  localparam logic [15:0] PARTNER_LOWER_OFS = 16'h0205;
  localparam logic [15:0] PARTNER_MIDDLE_OFS = 16'h0206;
  localparam logic [15:0] PARTNER_UPPER_OFS = 16'h0207;

  // Reset values
  localparam logic [15:0] LOCAL_ADVERT_UPPER_RST = 16'h0000;
  localparam logic [15:0] PARTNER_LOWER_RST = 16'h0000;
  localparam logic [15:0] PARTNER_HOLD_RST = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  // Local upper advertisement fields
  localparam int unsigned HIGH_LEVEL_TX_CAPABLE_BIT = 13;
  localparam int unsigned HIGH_LEVEL_TX_REQUEST_BIT = 12;

  // Partner lower word fields
  localparam int unsigned PARTNER_NEXT_PAGE_WANTED_BIT = 15;
  localparam int unsigned PARTNER_ACKNOWLEDGE_BIT = 14;
  localparam int unsigned PARTNER_REMOTE_FAULT_BIT = 13;
  localparam int unsigned PARTNER_ROLE_FORCED_BIT = 12;
  localparam int unsigned PARTNER_PAUSE_MSB = 11;
  localparam int unsigned PARTNER_PAUSE_LSB = 10;
  localparam int unsigned PARTNER_SELECTOR_MSB = 4;
  localparam int unsigned PARTNER_SELECTOR_LSB = 0;

  // Word positions inside the received 48-bit base page
  localparam int unsigned PAGE_LOWER_LSB = 0;
  localparam int unsigned PAGE_MIDDLE_LSB = 16;
  localparam int unsigned PAGE_UPPER_LSB = 32;

  // Implemented bits of each word; everything else reads as zero
  localparam logic [15:0] LOCAL_ADVERT_UPPER_MASK = 16'h3000;
  localparam logic [15:0] PARTNER_LOWER_MASK = 16'hfc1f;
  localparam logic [15:0] PARTNER_MIDDLE_MASK = 16'h40f0;
  localparam logic [15:0] PARTNER_UPPER_MASK = 16'h7000;

  // Strap settle time after reset release, in clock cycles
  localparam int unsigned STRAP_SETTLE_CYCLES = 2;

endpackage : autoneg_regs_pkg

/* File: hw/strap_capture.sv */
// Strap pin synchroniser that latches the straps once after reset release.
// Assumes strap pins are static while the device comes out of reset.
`timescale 1ns/1ps
module strap_capture #(
  parameter int unsigned WIDTH        = 2,
  parameter int unsigned SETTLE_COUNT = autoneg_regs_pkg::STRAP_SETTLE_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] strapPins,
  output logic      [WIDTH-1:0] strapValue,
  output logic                  strapLoad
);

  // Settle counter is four bits wide and needs two synchroniser stages to fill
  if (WIDTH < 1 || SETTLE_COUNT < 2 || SETTLE_COUNT > 15) begin : g_param_check
    $error("strap_capture: unsupported WIDTH or SETTLE_COUNT");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [3:0]       settle;
    logic             done;
    logic             load;
    logic [WIDTH-1:0] value;
  } strap_state_type;

  strap_state_type state_r;
  strap_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = strapPins;
    state_nxt.sync = state_r.meta;
    state_nxt.load = 1'b0;
    // Wait until the synchroniser holds post-reset samples only
    if (!state_r.done) begin
      if (state_r.settle == 4'(SETTLE_COUNT)) begin
        state_nxt.done = 1'b1;
        state_nxt.load = 1'b1;
        state_nxt.value = state_r.sync;
      end else begin
        state_nxt.settle = state_r.settle + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign strapValue = state_r.value;
  assign strapLoad  = state_r.load;

endmodule : strap_capture

/* File: hw/autoneg_tx_level_and_lp_base_page.sv */
// Autonegotiation transmit-level advertisement and partner base page registers.
// Assumes the receive path presents the partner base page on this clock.
// Function
// - Bit 13 advertises high level capability
// - Bit 12 advertises high level request
// - Either end incapable resolves to low
// - Both capable, one requesting: high level
// - Lower word read captures middle, upper
// - Bit 15 shows partner next page
// - Bit 14 shows partner acknowledge
// - Bit 13 shows partner remote fault
// - Bit 12: preferred zero, forced one
// - Field 11:10 shows partner pause support
// - Field 4:0 shows partner selector
// - Middle, upper reads return captured words
`timescale 1ns/1ps
module autoneg_tx_level_and_lp_base_page #(
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst_n,
  input  wire logic [ADDR_W-1:0]                    regAddr,
  input  wire logic [autoneg_regs_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                                 regWrEn,
  input  wire logic                                 regRdEn,
  output logic      [autoneg_regs_pkg::DATA_W-1:0]  regRdData,
  input  wire logic                                 strapHighCapable,
  input  wire logic                                 strapHighRequest,
  input  wire logic [autoneg_regs_pkg::PAGE_W-1:0]  partnerPage,
  input  wire logic                                 partnerPageValid,
  output logic                                      txLevelHigh
);

  if (ADDR_W < autoneg_regs_pkg::MIN_ADDR_W || ADDR_W > 16) begin : g_addr_w_check
    $error("autoneg_tx_level_and_lp_base_page: ADDR_W out of range");
  end

  typedef struct packed {
    logic        highLevelTxCapable;
    logic        highLevelTxRequest;
    logic [15:0] partnerMiddleHold;
    logic [15:0] partnerUpperHold;
    logic [15:0] readData;
    logic        txHigh;
  } bank_state_type;

  bank_state_type state_r;
  bank_state_type state_nxt;

  logic [1:0] strapValue;
  logic       strapLoad;
  logic [15:0] partnerLowerLive;
  logic [15:0] partnerMiddleLive;
  logic [15:0] partnerUpperLive;

  function automatic logic hitAddr(input logic [ADDR_W-1:0] addr, input logic [15:0] ofs);
    // Zero extension by cast avoids a zero-width replication at full width
    hitAddr = (16'(addr) == ofs);
  endfunction : hitAddr

  function automatic logic [15:0] pageWord(input logic [47:0] page, input int unsigned lsb);
    pageWord = page[lsb +: 16];
  endfunction : pageWord

  // Straps are pins, so they are synchronised before loading the defaults
  strap_capture #(
    .WIDTH        (2),
    .SETTLE_COUNT (autoneg_regs_pkg::STRAP_SETTLE_CYCLES)
  ) u_strap (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .strapPins  ({strapHighCapable, strapHighRequest}),
    .strapValue (strapValue),
    .strapLoad  (strapLoad)
  );

  // Partner fields pass straight through; unimplemented bits are masked off
  assign partnerLowerLive = pageWord(partnerPage, autoneg_regs_pkg::PAGE_LOWER_LSB)
                            & autoneg_regs_pkg::PARTNER_LOWER_MASK;
  assign partnerMiddleLive = pageWord(partnerPage, autoneg_regs_pkg::PAGE_MIDDLE_LSB)
                             & autoneg_regs_pkg::PARTNER_MIDDLE_MASK;
  assign partnerUpperLive = pageWord(partnerPage, autoneg_regs_pkg::PAGE_UPPER_LSB)
                            & autoneg_regs_pkg::PARTNER_UPPER_MASK;

  always_comb begin
    logic        lpCapable;
    logic        lpRequest;
    logic [15:0] localWord;
    lpCapable = 1'b0;
    lpRequest = 1'b0;
    localWord = 16'h0000;
    state_nxt = state_r;
    state_nxt.readData = autoneg_regs_pkg::READ_IDLE;

    // Strap defaults land once; a write in the same cycle still wins after
    if (strapLoad) begin
      state_nxt.highLevelTxCapable = strapValue[1];
      state_nxt.highLevelTxRequest = strapValue[0];
    end

    if (regWrEn && hitAddr(regAddr, autoneg_regs_pkg::LOCAL_ADVERT_UPPER_OFS)) begin
      state_nxt.highLevelTxCapable =
        regWrData[autoneg_regs_pkg::HIGH_LEVEL_TX_CAPABLE_BIT];
      state_nxt.highLevelTxRequest =
        regWrData[autoneg_regs_pkg::HIGH_LEVEL_TX_REQUEST_BIT];
    end

    localWord[autoneg_regs_pkg::HIGH_LEVEL_TX_CAPABLE_BIT] = state_r.highLevelTxCapable;
    localWord[autoneg_regs_pkg::HIGH_LEVEL_TX_REQUEST_BIT] = state_r.highLevelTxRequest;

    if (regRdEn) begin
      if (hitAddr(regAddr, autoneg_regs_pkg::LOCAL_ADVERT_UPPER_OFS)) begin
        state_nxt.readData = localWord & autoneg_regs_pkg::LOCAL_ADVERT_UPPER_MASK;
      end else if (hitAddr(regAddr, autoneg_regs_pkg::PARTNER_LOWER_OFS)) begin
        state_nxt.readData = partnerLowerLive;
        // Snapshot keeps the three words coherent across separate reads
        state_nxt.partnerMiddleHold = partnerMiddleLive;
        state_nxt.partnerUpperHold = partnerUpperLive;
      end else if (hitAddr(regAddr, autoneg_regs_pkg::PARTNER_MIDDLE_OFS)) begin
        state_nxt.readData = state_r.partnerMiddleHold;
      end else if (hitAddr(regAddr, autoneg_regs_pkg::PARTNER_UPPER_OFS)) begin
        state_nxt.readData = state_r.partnerUpperHold;
      end else begin
        state_nxt.readData = autoneg_regs_pkg::READ_IDLE;
      end
    end

    // Resolution uses the live page; no page received means low level
    lpCapable = partnerPageValid & partnerUpperLive[autoneg_regs_pkg::HIGH_LEVEL_TX_CAPABLE_BIT];
    lpRequest = partnerPageValid & partnerUpperLive[autoneg_regs_pkg::HIGH_LEVEL_TX_REQUEST_BIT];
    if (!state_r.highLevelTxCapable || !lpCapable) begin
      state_nxt.txHigh = 1'b0;
    end else begin
      state_nxt.txHigh = state_r.highLevelTxRequest | lpRequest;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r.highLevelTxCapable <=
        autoneg_regs_pkg::LOCAL_ADVERT_UPPER_RST[autoneg_regs_pkg::HIGH_LEVEL_TX_CAPABLE_BIT];
      state_r.highLevelTxRequest <=
        autoneg_regs_pkg::LOCAL_ADVERT_UPPER_RST[autoneg_regs_pkg::HIGH_LEVEL_TX_REQUEST_BIT];
      state_r.partnerMiddleHold  <= autoneg_regs_pkg::PARTNER_HOLD_RST;
      state_r.partnerUpperHold   <= autoneg_regs_pkg::PARTNER_HOLD_RST;
      state_r.readData           <= autoneg_regs_pkg::READ_IDLE;
      state_r.txHigh             <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdData   = state_r.readData;
  assign txLevelHigh = state_r.txHigh;

endmodule : autoneg_tx_level_and_lp_base_page

/* File: verification/autoneg_partner_model.sv */
// Link partner: presents its received base page to the block.
// Assumes the bench hands it pages on sys_clk.
`timescale 1ns/1ps
module autoneg_partner_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [47:0] newPage,
  input  wire logic        newValid,
  output logic      [47:0] partnerPage,
  output logic             partnerPageValid
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      partnerPage      <= 48'h0;
      partnerPageValid <= 1'b0;
    end else begin
      // Bits 45/44 carry its own ability and request
      partnerPage      <= {newPage[47:5], 5'h01}; // Standard selector
      partnerPageValid <= newValid;
    end
  end
endmodule : autoneg_partner_model

/* File: verification/autoneg_regs_monitor.sv */
// Checker on the register port and the resolved transmit level.
// Assumes one clock, sys_clk, and async active-low rst_n.
`timescale 1ns/1ps
module autoneg_regs_monitor #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0]       regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [15:0]       regRdData,
  input wire logic              strapHighCapable,
  input wire logic              strapHighRequest,
  input wire logic [47:0]       partnerPage,
  input wire logic              partnerPageValid,
  input wire logic              txLevelHigh
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] snap_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) snap_r <= 32'h0;
    else if (regRdEn && regAddr == 16'h0205) snap_r <= partnerPage[47:16];
  end
  property p_idle; !$past(regRdEn) |-> regRdData == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_lower; regRdEn && regAddr == 16'h0205
    |=> regRdData == ($past(partnerPage[15:0]) & 16'hfc1f); endproperty
  a_lower: assert property (p_lower) else $error("lower word wrong");
  property p_mid; regRdEn && regAddr == 16'h0206
    |=> regRdData == ($past(snap_r[15:0]) & 16'h40f0); endproperty
  a_mid: assert property (p_mid) else $error("middle word not held");
  property p_up; regRdEn && regAddr == 16'h0207
    |=> regRdData == ($past(snap_r[31:16]) & 16'h7000); endproperty
  a_up: assert property (p_up) else $error("upper word not held");
  property p_adv; regWrEn && regAddr == 16'h0204 ##1 !regWrEn ##1 regRdEn && regAddr == 16'h0204
    |=> regRdData == ($past(regWrData, 3) & 16'h3000); endproperty
  a_adv: assert property (p_adv) else $error("advert word wrong");
  property p_lpcap; txLevelHigh |-> $past(partnerPageValid && partnerPage[45]); endproperty
  a_lpcap: assert property (p_lpcap) else $error("high without partner");
  property p_high; (regWrEn && regAddr == 16'h0204 && regWrData[13:12] == 2'b11 ##1
    (partnerPageValid && partnerPage[45] && !regWrEn) [*2]) |-> txLevelHigh; endproperty
  a_high: assert property (p_high) else $error("level not high");
  property p_low; regWrEn && regAddr == 16'h0204 && !regWrData[13] ##1 !regWrEn
    |=> !txLevelHigh; endproperty
  a_low: assert property (p_low) else $error("level not low");
  c_high: cover property ($rose(txLevelHigh));
  c_snap: cover property (regRdEn && regAddr == 16'h0206);
  c_wr: cover property (regWrEn && regAddr == 16'h0204);
endmodule : autoneg_regs_monitor
bind autoneg_tx_level_and_lp_base_page autoneg_regs_monitor #(.ADDR_W(ADDR_W)) monitor_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .strapHighCapable(strapHighCapable), .strapHighRequest(strapHighRequest),
  .partnerPage(partnerPage), .partnerPageValid(partnerPageValid), .txLevelHigh(txLevelHigh));

/* File: verification/testbench.sv */
// Self-checking bench for the transmit-level and partner page registers.
// Assumes the partner model drives the received page.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic        sys_clk = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [15:0] regAddr = 16'h0, regWrData = 16'h0, regRdData, q, adv;
  logic [1:0]  straps = 2'b00;
  logic [47:0] newPage = 48'h0, partnerPage, page;
  logic        newValid = 1'b0, partnerPageValid, txLevelHigh;
  logic [31:0] lfsr = 32'h0929;
  logic [15:0] mdlAdv = 16'h0;
  int          n_fail = 0, n_compared = 0;
  autoneg_tx_level_and_lp_base_page autoneg_tx_level_and_lp_base_page_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .strapHighCapable(straps[1]), .strapHighRequest(straps[0]), .partnerPage(partnerPage),
    .partnerPageValid(partnerPageValid), .txLevelHigh(txLevelHigh));
  autoneg_partner_model autoneg_partner_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .newPage(newPage), .newValid(newValid), .partnerPage(partnerPage),
    .partnerPageValid(partnerPageValid));
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    // Model: only the advertisement word is writable, reserved bits drop
    if (a == 16'h0204) mdlAdv = d & 16'h3000;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    // Data stand for the one cycle after the strobe; take them at its end
    @(posedge sys_clk);
    d = regRdData;
  endtask : rd
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial forever #2.5 sys_clk = ~sys_clk;
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end
  initial begin
    straps = lfsr[1:0];
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    mdlAdv = {2'b00, straps, 12'h000};
    rd(16'h0204, q); `CHK(q, mdlAdv)
    // Partner always presents the standard selector, even before a page
    rd(16'h0205, q); `CHK(q, 16'h0001)
    rd(16'h0207, q); `CHK(q, 16'h0000)
    for (int i = 0; i < 16; i++) begin
      lfsr = nextRand(lfsr);
      page[31:0] = lfsr;
      lfsr = nextRand(lfsr);
      page[47:32] = {lfsr[15:14], i[3:2], lfsr[11:0]};
      page[4:0] = 5'h01;
      adv = {lfsr[31:30], i[1:0], lfsr[27:16]};
      // Write then read back at once, so the checker sees the pair
      wr(16'h0204, adv);
      rd(16'h0204, q); `CHK(q, mdlAdv)
      @(posedge sys_clk);
      newPage <= page;
      newValid <= (i != 15);
      repeat (3) @(posedge sys_clk);
      #1 `CHK(txLevelHigh, (i != 15) && adv[13] && page[45] && (adv[12] || page[44]))
      wr(16'h0205, adv);
      rd(16'h0205, q); `CHK(q, page[15:0] & 16'hfc1f)
      rd(16'h0204, q); `CHK(q, mdlAdv)
      @(posedge sys_clk);
      newPage <= ~page;
      rd(16'h0206, q); `CHK(q, page[31:16] & 16'h40f0)
      rd(16'h0207, q); `CHK(q, page[47:32] & 16'h7000)
      rd(16'h0300, q); `CHK(q, 16'h0000)
    end
    test_done();
  end
endmodule : testbench
